// ===== core/flgate_regs.vh
// Contract
// RL1: Lock level comes from status bits [7:5]; programmed lock bit reads as zero.
// RL2: Lock bit states stay readable even while ordinary reads are locked out.
// RL3: Refused external host read returns byte 00H.
// RL4: Refused in-application verify leaves flash data register unchanged.
// RL5: Refused code table read returns FFH, as if blank.
// RL6: Levels 111/011/101 refuse all verify; internal code reads allowed, ext-ext only 011/101.
// RL7: Levels 001/110: verify only block1 to block0; block0 code reads only block0.
// RL8: Level 010: host verify refused, in-app verify only across blocks, internal code reads free.
// RL9: Levels 100/000: host verify of both blocks allowed, independent of source.
// RL10: Levels 100/000: in-app verify internal only to other block; 000 also from external.
// RL11: Code reads never cross internal/external; verify never targets external.
// RL12: Requester, source and target are encoded inputs; allow and value same cycle.
`ifndef FLGATE_REGS_VH
`define FLGATE_REGS_VH
`define FLGATE_LOCK_MSB      7
`define FLGATE_LOCK_LSB      5
`define FLGATE_REQ_HOST      2'h0
`define FLGATE_REQ_INAPP     2'h1
`define FLGATE_REQ_TABLE     2'h2
`define FLGATE_REQ_STATUS    2'h3
`define FLGATE_REG_BLK0      2'h0
`define FLGATE_REG_BLK1      2'h1
`define FLGATE_REG_EXT       2'h2
`define FLGATE_HOST_DENY_VAL 8'h00
`define FLGATE_TABLE_DENY_VAL 8'hFF
`define FLGATE_STATUS_RST    8'hFF
`endif

// ===== core/flgate_data_hold.v
`timescale 1ns/1ps
`default_nettype none
`include "flgate_regs.vh"
module flgate_data_hold (
    input  wire       i_clock,
    input  wire       i_rst_n,
    input  wire       i_load,
    input  wire [7:0] i_data,
    output wire [7:0] o_data
);
    reg [7:0] data_reg;
    // Register only loads when a verify is allowed
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            data_reg <= 8'h00;
        end else if (i_load) begin
            data_reg <= i_data;
        end
    end
    assign o_data = data_reg;
endmodule // flgate_data_hold
`default_nettype wire

// ===== core/flgate_top.v
`timescale 1ns/1ps
`default_nettype none
`include "flgate_regs.vh"
module flgate_top (
    input  wire       I_CLOCK,
    input  wire       I_RST_N,
    input  wire [7:0] I_FLASH_STATUS,
    input  wire       I_REQ_VALID,
    input  wire [1:0] I_REQ_TYPE,
    input  wire [1:0] I_SRC_REGION,
    input  wire [1:0] I_TGT_REGION,
    input  wire [7:0] I_FLASH_BYTE,
    output wire       O_ALLOW,
    output wire [7:0] O_READ_DATA,
    output wire [7:0] O_FLASH_DATA,
    output wire [2:0] O_LOCK_BITS
);
    wire [2:0] lock = I_FLASH_STATUS[`FLGATE_LOCK_MSB:`FLGATE_LOCK_LSB]; // RL1
    wire s0 = (I_SRC_REGION == `FLGATE_REG_BLK0);
    wire s1 = (I_SRC_REGION == `FLGATE_REG_BLK1);
    wire t0 = (I_TGT_REGION == `FLGATE_REG_BLK0);
    wire t1 = (I_TGT_REGION == `FLGATE_REG_BLK1);
    wire s_int = s0 | s1;
    wire t_int = t0 | t1;
    wire s_ext = (I_SRC_REGION == `FLGATE_REG_EXT);
    wire t_ext = (I_TGT_REGION == `FLGATE_REG_EXT);
    reg host_ok;
    reg inapp_ok;
    reg tbl_ok;
    reg allow;
    reg [7:0] rdata;
    always @* begin
        host_ok = 1'b0;
        inapp_ok = 1'b0;
        tbl_ok = 1'b0;
        case (lock)
            3'h7: begin
                tbl_ok = s_int & t_int; // RL6
            end
            3'h3, 3'h5: begin
                tbl_ok = (s_int & t_int) | (s_ext & t_ext); // RL6
            end
            3'h1, 3'h6: begin
                inapp_ok = s1 & t0; // RL7
                tbl_ok = (s0 & t0) | (s1 & t_int) | (s_ext & t_ext); // RL7
            end
            3'h2: begin
                inapp_ok = (s0 & t1) | (s1 & t0); // RL8
                tbl_ok = (s_int & t_int) | (s_ext & t_ext); // RL8
            end
            3'h4: begin
                host_ok = t_int; // RL9
                inapp_ok = (s0 & t1) | (s1 & t0); // RL10
                tbl_ok = (s_int & t_int) | (s_ext & t_ext); // RL11
            end
            3'h0: begin
                host_ok = t_int; // RL9
                inapp_ok = (s0 & t1) | (s1 & t0) | (s_ext & t_int); // RL10
                tbl_ok = (s_int & t_int) | (s_ext & t_ext); // RL11
            end
            default: begin
                tbl_ok = 1'b0;
            end
        endcase
    end
    // Combinational answer so the CPU sees no added wait state
    always @* begin
        allow = 1'b0;
        rdata = I_FLASH_BYTE;
        case (I_REQ_TYPE)
            `FLGATE_REQ_HOST: begin
                allow = host_ok;
                rdata = host_ok ? I_FLASH_BYTE : `FLGATE_HOST_DENY_VAL; // RL3
            end
            `FLGATE_REQ_INAPP: begin
                allow = inapp_ok;
                rdata = inapp_ok ? I_FLASH_BYTE : O_FLASH_DATA; // RL4
            end
            `FLGATE_REQ_TABLE: begin
                allow = tbl_ok;
                rdata = tbl_ok ? I_FLASH_BYTE : `FLGATE_TABLE_DENY_VAL; // RL5
            end
            `FLGATE_REQ_STATUS: begin
                allow = 1'b1;
                rdata = {lock, 5'h00}; // RL2
            end
            default: begin
                allow = 1'b0;
            end
        endcase
    end
    assign O_ALLOW = allow & I_REQ_VALID; // RL12
    assign O_READ_DATA = I_REQ_VALID ? rdata : 8'h00; // RL12
    assign O_LOCK_BITS = lock; // RL2
    flgate_data_hold u_hold (
        .i_clock (I_CLOCK),
        .i_rst_n (I_RST_N),
        .i_load  (I_REQ_VALID & (I_REQ_TYPE == `FLGATE_REQ_INAPP) & inapp_ok), // RL4
        .i_data  (I_FLASH_BYTE),
        .o_data  (O_FLASH_DATA)
    );
endmodule // flgate_top
`default_nettype wire

// ===== sim/flgate_chk.sv
`timescale 1ns/1ps
`default_nettype none
module flgate_chk (
    input wire       I_CLOCK, I_RST_N, I_REQ_VALID, O_ALLOW,
    input wire [1:0] I_REQ_TYPE,
    input wire [2:0] O_LOCK_BITS,
    input wire [7:0] I_FLASH_STATUS, I_FLASH_BYTE, O_READ_DATA, O_FLASH_DATA
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    wire [2:0] t = {I_REQ_VALID, I_REQ_TYPE};
    wire [2:0] l = I_FLASH_STATUS[7:5];
    sequence s_ld; t == 5 && O_ALLOW; endsequence
    property p_lk; O_LOCK_BITS == l; endproperty
    a_lk: assert property (p_lk) else $error("lk");
    property p_st; t == 7 |-> O_ALLOW && O_READ_DATA == {l, 5'h00}; endproperty
    a_st: assert property (p_st) else $error("st");
    property p_ho; t == 4 && !O_ALLOW |-> O_READ_DATA == 8'h00; endproperty
    a_ho: assert property (p_ho) else $error("ho");
    // Software reads the old byte back, so a refusal must not touch it
    property p_kp; t == 5 && !O_ALLOW |=> $stable(O_FLASH_DATA); endproperty
    a_kp: assert property (p_kp) else $error("kp");
    property p_tb; t == 6 && !O_ALLOW |-> O_READ_DATA == 8'hFF; endproperty
    a_tb: assert property (p_tb) else $error("tb");
    property p_hd; t[2] && !t[1] && (l == 7 || l == 3 || l == 5) |-> !O_ALLOW; endproperty
    a_hd: assert property (p_hd) else $error("hd");
    property p_ld; s_ld |=> O_FLASH_DATA == $past(I_FLASH_BYTE); endproperty
    a_ld: assert property (p_ld) else $error("ld");
    property p_nv; !I_REQ_VALID |-> !O_ALLOW && O_READ_DATA == 8'h00; endproperty
    a_nv: assert property (p_nv) else $error("nv");
endmodule // flgate_chk
bind flgate_top flgate_chk chk (.*);
`default_nettype wire

// ===== sim/flgate_arr.sv
`timescale 1ns/1ps
`default_nettype none
module flgate_arr (
    input  wire logic       i_clock,
    output var logic  [7:0] o_byte
);
    // New byte every cycle, repeating every 30 cycles, so a read one cycle stale never matches by luck
    initial o_byte = 8'hA5;
    always @(posedge i_clock) o_byte <= {o_byte[6:0], o_byte[7] ^ o_byte[5]};
endmodule // flgate_arr
`default_nettype wire

// ===== sim/flgate_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_lock_read_gate_tb;
    logic clk = 0, rst_n = 0, v = 0, a;
    logic [7:0] st = 0, fd = 0, e;
    logic [1:0] ty = 0, sr = 0, tg = 0;
    logic [31:0] rs = 77851;
    wire [7:0] b, rd, fq;
    wire [2:0] lk;
    wire al;
    integer fail_count = 0, compares = 0, i;
    flgate_arr arr (.i_clock(clk), .o_byte(b));
    flgate_top dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_FLASH_STATUS(st), .I_REQ_VALID(v),
        .I_REQ_TYPE(ty), .I_SRC_REGION(sr), .I_TGT_REGION(tg), .I_FLASH_BYTE(b),
        .O_ALLOW(al), .O_READ_DATA(rd), .O_FLASH_DATA(fq), .O_LOCK_BITS(lk));
    initial forever #20 clk = ~clk;
    function logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ x << 5;
    endfunction
    function logic ok(input logic [2:0] l, input logic [1:0] t, s, g);
        return t == 3 || g < 2 && (t == 0 && l[1:0] == 0 ||
            t == 2 && s < 2 && !(s == 0 && g == 1 && (l == 1 || l == 6)) || t == 1 &&
            (s == 2 ? l == 0 : s != g && (l == 0 || l == 2 || l == 4 || s && (l == 1 || l == 6))))
            || t == 2 && s == 2 && g == 2 && l != 7;
    endfunction
    task chk(input logic [7:0] s, x);
        compares++;
        if (s !== x) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, s, x);
        end
    endtask
    task end_of_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        // First 288 steps sweep every level, kind and region pair
        for (i = 0; i < 900; i++) begin
            @(posedge clk);
            rs = xs(rs);
            rst_n <= i != 700;
            v <= i < 288 || rs[9];
            st <= i < 288 ? {i[2:0], rs[4:0]} : rs[7:0];
            ty <= i < 288 ? i[4:3] : rs[11:10];
            sr <= i < 288 ? i / 32 % 3 : rs[15:12] % 3;
            tg <= i < 288 ? i / 96 : rs[19:16] % 3;
            @(negedge clk);
            a = v && ok(st[7:5], ty, sr, tg);
            e = a ? b : ty == 0 ? 8'h00 : ty == 1 ? fd : 8'hFF;
            chk(al, a);
            chk(rd, !v ? 8'h00 : ty == 3 ? {st[7:5], 5'h00} : e);
            chk(fq, fd);
            chk(lk, st[7:5]);
            fd = !rst_n ? 8'h00 : a && ty == 1 ? b : fd;
            if (i == 287 || i == 899)
                $display("test %0d done", i);
        end
        end_of_test;
    end
endmodule // flash_lock_read_gate_tb
`default_nettype wire
